/* File: verilog/eab_top.sv */
// eab_top.sv - autobaud detection and asynchronous transmitter with an ahb-lite slave
// assumes: core_clk is the oscillator, all inputs are synchronous to it, one bus slave
//
// What this block does
// - Rate measurement only runs with asynchronous mode selected; wake enable delays it.
// - Setting autobaud enable clears the counter, then waits for a start bit.
// - Counting starts at first rising edge, stops at fifth, result in divisor pair.
// - The fifth rising edge clears autobaud enable automatically.
// - Counter rollover sets the overflow flag; measurement continues; software may write it.
// - Calibration counter runs at one eighth of the configured generator clock.
// - During calibration both divisor bytes form one 16-bit counter.
// - Serial machine held idle; receive pending set at fifth edge; buffer read clears it.
// - With wake enable, measurement uses the character after the break.
// - Transmit buffer writes ignored while autobaud enable is set.
// - Asynchronous frames: one start bit, eight or nine data bits, one stop bit.
// - Data goes out least significant bit first, one shared format and rate.
// - Generator steps every sixty-four, sixteen or four oscillator cycles by the speed selects.
// - No hardware parity; a ninth bit carries whatever software supplies.
// - Shifter reloads only after the stop bit, then at once from a full buffer.
// - Buffer to shifter transfer takes one instruction cycle, then buffer is empty.
// - Buffer empty flag not software clearable, valid two instruction cycles after a write.
// - Shifter empty status is read only and has no interrupt path.
// - Setting transmit enable sets the buffer empty flag at once.
`timescale 1ns/1ps
`include "eab_defines.svh"

module eab_top (
    // clock and reset
    input  wire logic        core_clk,
    input  wire logic        reset_n,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // serial line
    input  wire logic        receive_pin,
    output logic             transmit_pin
);
    // reset release synchroniser
    logic                rst_meta_r;
    logic                rst_n_s;
    // software visible state, plus the internal buffer full bit and empty flag pipe stage
    logic                nine_bit_transmit_r;
    logic                transmit_enable_r;
    logic                sync_select_r;
    logic                high_speed_select_r;
    logic                ninth_transmit_bit_r;
    logic                serial_port_enable_r;
    logic                autobaud_overflow_flag_r;
    logic                wide_divisor_select_r;
    logic                wake_on_break_enable_r;
    logic                autobaud_enable_r;
    logic [7:0]          rate_divisor_low_r;
    logic [7:0]          rate_divisor_high_r;
    logic [7:0]          transmit_buffer_r;
    logic                tbuf_full_r;
    logic                receive_pending_flag_r;
    logic                tbe_pipe_r;
    logic                transmit_buffer_empty_flag_r;
    // bus phase tracking
    logic                wr_pend_r;
    logic                rd_pend_r;
    logic [7:0]          addr_r;
    // timing
    logic [1:0]          tcy_cnt_r;
    logic [9:0]          presc_r;
    logic [15:0]         dcnt_r;
    logic                rx_q_r;
    // calibration and transmit state
    eab_pkg::eab_cal_e   cal_state_r;
    eab_pkg::eab_cal_e   cal_nxt;
    logic [2:0]          cal_edges_r;
    eab_pkg::eab_tx_e    tx_state_r;
    logic [8:0]          shift_r;
    logic [3:0]          bits_left_r;
    // reset is released through two flops, asserted at once
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_meta_r <= 1'b0;
            rst_n_s    <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_n_s    <= rst_meta_r;
        end
    end
    // bus decode: every access completes with okay, unmapped reads give zero
    wire       bus_take   = hsel & hready & htrans[1];
    wire       wr_commit  = wr_pend_r;
    wire       rd_commit  = rd_pend_r;
    wire       wr_tx_stat = wr_commit & (addr_r == `EAB_OFF_TX_STATUS);
    wire       wr_port    = wr_commit & (addr_r == `EAB_OFF_PORT_CTRL);
    wire       wr_baud    = wr_commit & (addr_r == `EAB_OFF_BAUD_CTRL);
    wire       wr_div_lo  = wr_commit & (addr_r == `EAB_OFF_DIV_LO);
    wire       wr_div_hi  = wr_commit & (addr_r == `EAB_OFF_DIV_HI);
    wire       wr_tbuf    = wr_commit & (addr_r == `EAB_OFF_TX_BUF) & ~autobaud_enable_r;
    wire       rd_rx_buf  = rd_commit & (addr_r == `EAB_OFF_RX_BUF);
    wire [7:0] wbyte      = hwdata[7:0];
    // register read multiplexer, evaluated in the read data phase
    wire       shifter_empty = (tx_state_r == eab_pkg::EAB_TX_IDLE);
    wire [7:0] rd_tx_stat = {1'b0, nine_bit_transmit_r, transmit_enable_r, sync_select_r,
                             1'b0, high_speed_select_r, shifter_empty, ninth_transmit_bit_r};
    wire [7:0] rd_baud    = {autobaud_overflow_flag_r, 3'h0, wide_divisor_select_r, 1'b0,
                             wake_on_break_enable_r, autobaud_enable_r};
    wire [7:0] rd_flags   = {6'h00, receive_pending_flag_r, transmit_buffer_empty_flag_r};
    wire [7:0] rd_byte    =
        (addr_r == `EAB_OFF_TX_STATUS) ? rd_tx_stat :
        (addr_r == `EAB_OFF_PORT_CTRL) ? {serial_port_enable_r, 7'h00} :
        (addr_r == `EAB_OFF_BAUD_CTRL) ? rd_baud :
        (addr_r == `EAB_OFF_DIV_LO)    ? rate_divisor_low_r :
        (addr_r == `EAB_OFF_DIV_HI)    ? rate_divisor_high_r :
        (addr_r == `EAB_OFF_TX_BUF)    ? transmit_buffer_r :
        (addr_r == `EAB_OFF_RX_BUF)    ? `EAB_RX_BUF_VALUE :
        (addr_r == `EAB_OFF_FLAGS)     ? rd_flags : `EAB_RST_BYTE;
    // a read costs one wait state so it always sees a write that just went before it
    always_ff @(posedge core_clk or negedge rst_n_s) begin
        if (!rst_n_s) begin
            wr_pend_r <= 1'b0;
            rd_pend_r <= 1'b0;
            addr_r    <= 8'h00;
            hreadyout <= 1'b1;
            hrdata    <= 32'h0000_0000;
            hresp     <= 1'b0;
        end else begin
            wr_pend_r <= bus_take & hwrite;
            rd_pend_r <= bus_take & ~hwrite;
            hreadyout <= ~(bus_take & ~hwrite);
            if (bus_take) begin
                addr_r <= (haddr[31:8] == 24'h00_0000) ? haddr[7:0] : 8'hff;
            end
            if (rd_commit) begin
                hrdata <= {24'h00_0000, rd_byte};
            end
        end
    end
    // instruction cycle enable: one pulse every four oscillator cycles
    wire tcy_tick = (tcy_cnt_r == `EAB_TCY_LAST);
    // prescale: 64, 16 or 4 oscillator cycles per tick, eight times that while calibrating
    wire       cal_counting = (cal_state_r == eab_pkg::EAB_CAL_COUNT);
    wire       cal_busy     = (cal_state_r != eab_pkg::EAB_CAL_IDLE);
    wire [9:0] pre_norm     =
        ({wide_divisor_select_r, high_speed_select_r} == 2'b00) ? `EAB_PRE_SLOW :
        ({wide_divisor_select_r, high_speed_select_r} == 2'b11) ? `EAB_PRE_FAST :
                                                                  `EAB_PRE_MID;
    wire [9:0] pre_lim      = cal_busy ? (pre_norm << `EAB_CAL_SHIFT) : pre_norm;
    wire       ptick        = (presc_r >= pre_lim - 10'h001); // no stall if the limit drops
    // divisor as seen by the generator: high byte dropped in 8-bit mode
    wire [15:0] div_val     = {wide_divisor_select_r ? rate_divisor_high_r : 8'h00,
                               rate_divisor_low_r};
    // one bit period is (divisor + 1) prescale ticks; stalled while calibrating
    wire       bit_tick     = ptick & (dcnt_r == 16'h0000) & ~cal_busy;

    always_ff @(posedge core_clk or negedge rst_n_s) begin
        if (!rst_n_s) begin
            tcy_cnt_r <= 2'h0;
            presc_r   <= 10'h000;
            dcnt_r    <= `EAB_RST_DIV;
            rx_q_r    <= 1'b1;
        end else begin
            tcy_cnt_r <= tcy_cnt_r + 2'h1;
            presc_r   <= ptick ? 10'h000 : presc_r + 10'h001;
            rx_q_r    <= receive_pin;
            if (cal_busy) begin
                dcnt_r <= `EAB_RST_DIV;
            end else if (ptick) begin
                dcnt_r <= (dcnt_r == 16'h0000) ? div_val : dcnt_r - 16'h0001;
            end
        end
    end
    // line edges; the pin is taken as already synchronous
    wire rx_rise = ~rx_q_r & receive_pin;
    wire rx_fall = rx_q_r & ~receive_pin;
    wire cal_run = autobaud_enable_r & ~sync_select_r;
    wire cal_done = cal_counting & rx_rise & (cal_edges_r == `EAB_CAL_EDGES);
    wire cal_start = (cal_state_r == eab_pkg::EAB_CAL_IDLE) & cal_run;
    // calibration sequencer
    always_comb begin
        cal_nxt = cal_state_r;
        case (cal_state_r)
            eab_pkg::EAB_CAL_IDLE: begin
                if (cal_run) begin
                    // with wake enabled the break itself is skipped
                    cal_nxt = wake_on_break_enable_r ? eab_pkg::EAB_CAL_BREAK
                                                     : eab_pkg::EAB_CAL_START;
                end
            end
            eab_pkg::EAB_CAL_BREAK: begin
                if (rx_rise) begin
                    cal_nxt = eab_pkg::EAB_CAL_START;
                end
            end
            eab_pkg::EAB_CAL_START: begin
                if (rx_fall) begin
                    cal_nxt = eab_pkg::EAB_CAL_FIRST;
                end
            end
            eab_pkg::EAB_CAL_FIRST: begin
                if (rx_rise) begin
                    cal_nxt = eab_pkg::EAB_CAL_COUNT;
                end
            end
            eab_pkg::EAB_CAL_COUNT: begin
                if (cal_done) begin
                    cal_nxt = eab_pkg::EAB_CAL_IDLE;
                end
            end
            default: begin
                cal_nxt = eab_pkg::EAB_CAL_IDLE;
            end
        endcase
        // software abort drops the sequence wherever it stands
        if (!cal_run) begin
            cal_nxt = eab_pkg::EAB_CAL_IDLE;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n_s) begin
        if (!rst_n_s) begin
            cal_state_r <= eab_pkg::EAB_CAL_IDLE;
            cal_edges_r <= 3'h0;
        end else begin
            cal_state_r <= cal_nxt;
            if (cal_state_r == eab_pkg::EAB_CAL_FIRST) begin
                cal_edges_r <= 3'h1;
            end else if (cal_counting & rx_rise) begin
                cal_edges_r <= cal_edges_r + 3'h1;
            end
        end
    end
    // divisor pair: software writes, or the calibration counter across both bytes
    wire        cal_inc  = cal_counting & ptick & ~cal_done;
    wire [15:0] div_pair = {rate_divisor_high_r, rate_divisor_low_r};
    wire [15:0] div_inc  = div_pair + 16'h0001;
    wire        cal_roll = cal_inc & (div_pair == `EAB_DIV_ALL_ONES);
    always_ff @(posedge core_clk or negedge rst_n_s) begin
        if (!rst_n_s) begin
            rate_divisor_low_r  <= `EAB_RST_BYTE;
            rate_divisor_high_r <= `EAB_RST_BYTE;
        end else if (cal_start) begin
            rate_divisor_low_r  <= 8'h00;
            rate_divisor_high_r <= 8'h00;
        end else if (cal_inc) begin
            rate_divisor_low_r  <= div_inc[7:0];
            rate_divisor_high_r <= div_inc[15:8];
        end else begin
            if (wr_div_lo) begin
                rate_divisor_low_r <= wbyte;
            end
            if (wr_div_hi) begin
                rate_divisor_high_r <= wbyte;
            end
        end
    end
    // baud control: the hardware enable clear and overflow set beat a same-cycle write
    always_ff @(posedge core_clk or negedge rst_n_s) begin
        if (!rst_n_s) begin
            autobaud_overflow_flag_r <= 1'b0;
            wide_divisor_select_r    <= 1'b0;
            wake_on_break_enable_r   <= 1'b0;
            autobaud_enable_r        <= 1'b0;
        end else begin
            if (wr_baud) begin
                wide_divisor_select_r  <= wbyte[`EAB_BC_WIDE_DIV];
                wake_on_break_enable_r <= wbyte[`EAB_BC_WAKE_BREAK];
            end
            if (cal_done) begin
                autobaud_enable_r <= 1'b0;
            end else if (wr_baud) begin
                autobaud_enable_r <= wbyte[`EAB_BC_AUTOBAUD_EN];
            end
            if (cal_roll) begin
                autobaud_overflow_flag_r <= 1'b1;
            end else if (wr_baud) begin
                autobaud_overflow_flag_r <= wbyte[`EAB_BC_OVERFLOW];
            end
        end
    end
    // receive pending: the receiver stays idle, only calibration raises it
    always_ff @(posedge core_clk or negedge rst_n_s) begin
        if (!rst_n_s) begin
            receive_pending_flag_r <= 1'b0;
        end else if (cal_done) begin
            receive_pending_flag_r <= 1'b1;
        end else if (rd_rx_buf) begin
            receive_pending_flag_r <= 1'b0;
        end
    end
    // transmit status and port control
    always_ff @(posedge core_clk or negedge rst_n_s) begin
        if (!rst_n_s) begin
            nine_bit_transmit_r  <= 1'b0;
            transmit_enable_r    <= 1'b0;
            sync_select_r        <= 1'b0;
            high_speed_select_r  <= 1'b0;
            ninth_transmit_bit_r <= 1'b0;
            serial_port_enable_r <= 1'b0;
        end else begin
            if (wr_tx_stat) begin
                nine_bit_transmit_r  <= wbyte[`EAB_TS_NINE_BIT];
                transmit_enable_r    <= wbyte[`EAB_TS_TX_EN];
                sync_select_r        <= wbyte[`EAB_TS_SYNC];
                high_speed_select_r  <= wbyte[`EAB_TS_HIGH_SPEED];
                ninth_transmit_bit_r <= wbyte[`EAB_TS_NINTH_BIT];
            end
            if (wr_port) begin
                serial_port_enable_r <= wbyte[`EAB_PC_PORT_EN];
            end
        end
    end
    // empty flag trails the buffer by two instruction cycles, so an early poll reads stale
    wire tx_ready = transmit_enable_r & serial_port_enable_r & ~sync_select_r;
    wire tx_load  = tx_ready & tbuf_full_r & tcy_tick
                    & (tx_state_r == eab_pkg::EAB_TX_IDLE);
    wire transmit_enable_set = wr_tx_stat & wbyte[`EAB_TS_TX_EN] & ~transmit_enable_r;
    always_ff @(posedge core_clk or negedge rst_n_s) begin
        if (!rst_n_s) begin
            transmit_buffer_r            <= `EAB_RST_BYTE;
            tbuf_full_r                  <= 1'b0;
            tbe_pipe_r                   <= 1'b0;
            transmit_buffer_empty_flag_r <= 1'b0;
        end else begin
            if (wr_tbuf) begin
                transmit_buffer_r <= wbyte;
                tbuf_full_r       <= 1'b1;
            end else if (tx_load) begin
                tbuf_full_r       <= 1'b0;
            end
            if (transmit_enable_set) begin
                tbe_pipe_r                   <= 1'b1;
                transmit_buffer_empty_flag_r <= 1'b1;
            end else if (tcy_tick) begin
                tbe_pipe_r                   <= ~tbuf_full_r | tx_load;
                transmit_buffer_empty_flag_r <= tbe_pipe_r;
            end
        end
    end
    // transmit shifter: no parity logic, eight or nine bits go out exactly as loaded
    wire [3:0] data_bits = nine_bit_transmit_r ? 4'h9 : 4'h8;
    always_ff @(posedge core_clk or negedge rst_n_s) begin
        if (!rst_n_s) begin
            tx_state_r   <= eab_pkg::EAB_TX_IDLE;
            shift_r      <= 9'h000;
            bits_left_r  <= 4'h0;
            transmit_pin <= 1'b1;
        end else begin
            case (tx_state_r)
                eab_pkg::EAB_TX_IDLE: begin
                    transmit_pin <= 1'b1;
                    if (tx_load) begin
                        shift_r     <= {ninth_transmit_bit_r, transmit_buffer_r};
                        bits_left_r <= data_bits;
                        tx_state_r  <= eab_pkg::EAB_TX_ALIGN;
                    end
                end
                eab_pkg::EAB_TX_ALIGN: begin
                    // the start bit waits for a bit boundary so it is full length
                    if (bit_tick) begin
                        transmit_pin <= 1'b0;
                        tx_state_r   <= eab_pkg::EAB_TX_START;
                    end
                end
                eab_pkg::EAB_TX_START, eab_pkg::EAB_TX_DATA: begin
                    if (bit_tick) begin
                        if (bits_left_r == 4'h0) begin
                            transmit_pin <= 1'b1;
                            tx_state_r   <= eab_pkg::EAB_TX_STOP;
                        end else begin
                            transmit_pin <= shift_r[0];
                            shift_r      <= {1'b0, shift_r[8:1]};
                            bits_left_r  <= bits_left_r - 4'h1;
                            tx_state_r   <= eab_pkg::EAB_TX_DATA;
                        end
                    end
                end
                eab_pkg::EAB_TX_STOP: begin
                    if (bit_tick) begin
                        tx_state_r <= eab_pkg::EAB_TX_IDLE;
                    end
                end
                default: begin
                    tx_state_r   <= eab_pkg::EAB_TX_IDLE;
                    transmit_pin <= 1'b1;
                end
            endcase
        end
    end

endmodule : eab_top

/* File: verilog/eab_defines.svh */
// eab_defines.svh - register offsets, bit positions, reset values and timing counts
// assumes: included by bare name from the autobaud serial block sources
`ifndef EAB_DEFINES_SVH
`define EAB_DEFINES_SVH

// register byte offsets on the bus (one aligned word each)
`define EAB_OFF_TX_STATUS   8'h00
`define EAB_OFF_PORT_CTRL   8'h04
`define EAB_OFF_BAUD_CTRL   8'h08
`define EAB_OFF_DIV_LO      8'h0c
`define EAB_OFF_DIV_HI      8'h10
`define EAB_OFF_TX_BUF      8'h14
`define EAB_OFF_RX_BUF      8'h18
`define EAB_OFF_FLAGS       8'h1c

// transmit_status_reg bits
`define EAB_TS_NINE_BIT     6
`define EAB_TS_TX_EN        5
`define EAB_TS_SYNC         4
`define EAB_TS_HIGH_SPEED   2
`define EAB_TS_SHIFT_EMPTY  1
`define EAB_TS_NINTH_BIT    0
// port control bits
`define EAB_PC_PORT_EN      7
// baud_control_reg bits
`define EAB_BC_OVERFLOW     7
`define EAB_BC_WIDE_DIV     3
`define EAB_BC_WAKE_BREAK   1
`define EAB_BC_AUTOBAUD_EN  0
// flag register bits
`define EAB_FL_RX_PEND      1
`define EAB_FL_TX_EMPTY     0

// reset values
`define EAB_RST_BYTE        8'h00
`define EAB_RST_DIV         16'h0000
`define EAB_RX_BUF_VALUE    8'h00

// timing: core clock cycles per instruction cycle, and prescale per mode
`define EAB_TCY_LAST        2'h3
`define EAB_PRE_SLOW        10'h040
`define EAB_PRE_MID         10'h010
`define EAB_PRE_FAST        10'h004
`define EAB_CAL_SHIFT       3
`define EAB_CAL_EDGES       3'h4
`define EAB_DIV_ALL_ONES    16'hffff

`endif

/* File: verilog/eab_pkg.sv */
// eab_pkg.sv - state types of the autobaud serial block
// assumes: constants come from eab_defines.svh
package eab_pkg;

    // calibration sequencer states
    typedef enum logic [4:0] {
        EAB_CAL_IDLE  = 5'b00001,
        EAB_CAL_BREAK = 5'b00010,
        EAB_CAL_START = 5'b00100,
        EAB_CAL_FIRST = 5'b01000,
        EAB_CAL_COUNT = 5'b10000
    } eab_cal_e;

    // transmit shifter states
    typedef enum logic [4:0] {
        EAB_TX_IDLE  = 5'b00001,
        EAB_TX_ALIGN = 5'b00010,
        EAB_TX_START = 5'b00100,
        EAB_TX_DATA  = 5'b01000,
        EAB_TX_STOP  = 5'b10000
    } eab_tx_e;

endpackage : eab_pkg

/* File: testbench/eab_top_chk.sv */
// eab_top_chk.sv - bus and serial line checks on the block's ports
// assumes: bound to eab_top, one clock, hready tied to hreadyout
`timescale 1ns/1ps
module eab_top_chk (
    // clock, reset, bus and line, packed to save room
    input wire logic        core_clk, reset_n, hsel, hwrite, hready, hreadyout, hresp,
    input wire logic        transmit_pin,
    input wire logic [1:0]  htrans,
    input wire logic [31:0] hrdata
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    // a read address phase taken by the slave
    wire logic rd_go = hsel && hready && htrans[1] && !hwrite;

    hresp_okay_a: assert property (hresp == 1'b0) else $error("error response seen");
    upper_zero_a: assert property (hrdata[31:8] == 24'h0) else $error("upper read bits set");
    read_wait_a: assert property (rd_go |=> !hreadyout ##1 hreadyout)
        else $error("read wait state wrong");
    wait_single_a: assert property ($fell(hreadyout) |=> hreadyout) else $error("wait too long");
    no_stall_a: assert property (hreadyout && !rd_go |=> hreadyout)
        else $error("stall without a read");
    rdata_hold_a: assert property (!$stable(hrdata) |-> $rose(hreadyout))
        else $error("read data moved");
    // shortest bit is four clocks, so any level change holds at least that long
    start_len_a: assert property ($fell(transmit_pin) |=> !transmit_pin[*3])
        else $error("low bit too short");
    mark_len_a: assert property ($rose(transmit_pin) |=> transmit_pin[*3])
        else $error("high bit too short");
    read_seen_c: cover property (rd_go ##2 hreadyout);
    frame_seen_c: cover property ($fell(transmit_pin));
    line_back_c: cover property ($rose(transmit_pin));
endmodule : eab_top_chk

bind eab_top eab_top_chk eab_top_chk_inst (.core_clk(core_clk), .reset_n(reset_n), .hsel(hsel),
    .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
    .transmit_pin(transmit_pin), .htrans(htrans), .hrdata(hrdata));

/* File: testbench/eab_remote.sv */
// eab_remote.sv - remote serial station: sends calibration frames, samples our frames
// assumes: bit lengths given in core clocks by the caller
`timescale 1ns/1ps
module eab_remote (
    // line side
    input wire logic core_clk,
    input wire logic transmit_pin,
    output logic     receive_pin
);
    initial receive_pin = 1'b1; // pulled-up line idles at mark
    // whole frame, lsb first, line back to mark after the stop bit
    task automatic send(input logic [7:0] c, input int bitlen);
        logic [9:0] f;
        f = {1'b1, c, 1'b0};
        for (int i = 0; i < 10; i++) begin
            receive_pin <= f[i];
            repeat (bitlen) @(posedge core_clk);
        end
    endtask : send
    // mid-bit sampling; d[9] is the stop bit, unknown if no start came
    task automatic recv(input logic nine, input int bitlen, output logic [9:0] d);
        int n;
        d = 'x;
        for (n = 0; n < 20000; n++) begin
            @(posedge core_clk);
            if (transmit_pin === 1'b0) break;
        end
        if (n == 20000) return;
        d = '0;
        repeat (bitlen / 2) @(posedge core_clk);
        for (int i = 0; i < 9 + nine; i++) begin
            repeat (bitlen) @(posedge core_clk);
            d[(i == 8 && !nine) ? 9 : i] = transmit_pin;
        end
    endtask : recv
endmodule : eab_remote

/* File: testbench/uart_autobaud_and_async_tx_test.sv */
// uart_autobaud_and_async_tx_test.sv - self-checking bench for the autobaud serial block
// assumes: single bus master here, remote station model on the serial pins
`timescale 1ns/1ps
`include "eab_defines.svh"
module uart_autobaud_and_async_tx_test;
    logic        core_clk = 1'b0;
    logic        reset_n = 1'b0;
    logic        hsel = 1'b0;
    logic        hwrite = 1'b0;
    logic [1:0]  htrans = 2'h0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata, q, seed = 32'hbfd7;
    logic        hreadyout, hresp, rx_line, tx_line, nb;
    logic [9:0]  got_a, got_b;
    logic [7:0]  div, c0, c1;
    int          miscompares = 0, samples_checked = 0, bl;

    always #2.5 core_clk = ~core_clk;
    eab_top eab_top_inst (.core_clk(core_clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .receive_pin(rx_line),
        .transmit_pin(tx_line));
    eab_remote eab_remote_inst (.core_clk(core_clk), .transmit_pin(tx_line),
        .receive_pin(rx_line));

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xs
    // frame as sampled: stop, ninth bit, data
    function automatic logic [31:0] exp_frame(logic n, logic [7:0] c);
        return {22'h0, 1'b1, n, c};
    endfunction : exp_frame
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : give_verdict
    task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // one single transfer: address phase, then data phase, each held until hready
    task automatic bus(logic [7:0] a, logic w, logic [7:0] d, output logic [31:0] r);
        int n;
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        for (n = 0; n < 64; n++) begin @(posedge core_clk); if (hreadyout === 1'b1) break; end
        if (n == 64) begin miscompares++; give_verdict(); end
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= {24'h0, d};
        for (n = 0; n < 64; n++) begin @(posedge core_clk); if (hreadyout === 1'b1) break; end
        r = hrdata;
        if (n == 64) begin miscompares++; give_verdict(); end
    endtask : bus

    initial begin
        repeat (100000) @(posedge core_clk);
        miscompares++;
        give_verdict();
    end
    initial begin
        repeat (2) @(posedge core_clk);
        reset_n <= 1'b1;
        repeat (4) @(posedge core_clk);
        bus(`EAB_OFF_TX_STATUS, 0, 0, q); chk("tx status", 32'h2, q);
        bus(`EAB_OFF_FLAGS, 0, 0, q); chk("flags", 32'h0, q);
        div = 8'h1 + (xs() & 8'h3);
        nb = xs() & 1;
        bl = 4 * (div + 1); // fast mode: four clocks per divisor step
        bus(`EAB_OFF_DIV_LO, 1, div, q);
        bus(`EAB_OFF_BAUD_CTRL, 1, 8'h08, q);
        bus(`EAB_OFF_PORT_CTRL, 1, 8'h80, q);
        bus(`EAB_OFF_TX_STATUS, 1, {1'b0, nb, 6'h25}, q);
        bus(`EAB_OFF_FLAGS, 0, 0, q); chk("empty after enable", 32'h1, q);
        c0 = xs();
        c1 = xs();
        fork
            begin
                eab_remote_inst.recv(nb, bl, got_a);
                eab_remote_inst.recv(nb, bl, got_b);
            end
            begin
                bus(`EAB_OFF_TX_BUF, 1, c0, q);
                repeat (8) @(posedge core_clk); // two instruction cycles for the move
                bus(`EAB_OFF_TX_BUF, 1, c1, q);
                repeat (8) @(posedge core_clk);
                bus(`EAB_OFF_FLAGS, 0, 0, q); chk("buffer held", 32'h0, q);
            end
        join
        chk("frame a", exp_frame(nb, c0), {22'h0, got_a});
        chk("frame b", exp_frame(nb, c1), {22'h0, got_b});
        repeat (2 * bl) @(posedge core_clk);
        bus(`EAB_OFF_TX_STATUS, 0, 0, q); chk("shifter empty", 32'h2, q & 32'h2);
        bus(`EAB_OFF_DIV_HI, 1, xs(), q);
        bus(`EAB_OFF_BAUD_CTRL, 1, 8'h01, q); // narrow divisor mode, high speed kept
        bus(`EAB_OFF_DIV_LO, 0, 0, q); chk("divisor cleared", 32'h0, q);
        bus(`EAB_OFF_TX_BUF, 1, ~c1, q);
        bus(`EAB_OFF_TX_BUF, 0, 0, q); chk("buffer locked", {24'h0, c1}, q);
        bl = 16 * (260 + (xs() & 7)); // count lands above 255 to show all 16 bits count
        eab_remote_inst.send(8'h55, bl);
        repeat (4) @(posedge core_clk);
        bus(`EAB_OFF_BAUD_CTRL, 0, 0, q); chk("enable cleared", 32'h0, q);
        bus(`EAB_OFF_FLAGS, 0, 0, q); chk("pending set", 32'h2, q & 32'h2);
        bus(`EAB_OFF_DIV_HI, 0, 0, q);
        c0 = q[7:0];
        bus(`EAB_OFF_DIV_LO, 0, 0, q);
        // eight bit times at one step per 128 clocks; allow one step of edge phase
        q = {16'h0, c0, q[7:0]} - bl / 16 + 1;
        chk("measured divisor", 32'h1, (q <= 2) ? 32'h1 : q);
        bus(`EAB_OFF_RX_BUF, 0, 0, q);
        bus(`EAB_OFF_FLAGS, 0, 0, q); chk("pending cleared", 32'h0, q & 32'h2);
        give_verdict();
    end
endmodule : uart_autobaud_and_async_tx_test
